// file: pkg/amc_pkg.sv
package amc_pkg;

	// register addresses on the plain register port
	localparam logic [7:0] AMC_ADDR_GEN_CFG = 8'h40;
	localparam logic [7:0] AMC_ADDR_CONV_TIMING = 8'h41;
	localparam logic [7:0] AMC_ADDR_IRQ_STATUS = 8'h60;
	localparam logic [7:0] AMC_ADDR_IRQ_MASK = 8'h61;

	// reset values
	localparam logic [15:0] AMC_GEN_CFG_RST = 16'h3334;
	localparam logic [15:0] AMC_CONV_TIMING_RST = 16'h0555;
	localparam logic [3:0] AMC_IRQ_STATUS_RST = 4'h0;
	localparam logic [3:0] AMC_IRQ_MASK_RST = 4'h0;

	// writable bits; everything else is reserved and reads zero
	localparam logic [15:0] AMC_GEN_CFG_WMASK = 16'h7776;
	localparam logic [15:0] AMC_CONV_TIMING_WMASK = 16'h0777;

	// field positions (low bit of each field)
	localparam int AMC_EXT_FILTER_LSB = 12;
	localparam int AMC_SHUNT_FILTER_LSB = 8;
	localparam int AMC_TEMP_FILTER_LSB = 4;
	localparam int AMC_MODE_BIT = 2;
	localparam int AMC_SHUNT_RANGE_BIT = 1;
	localparam int AMC_TEMP_CONV_LSB = 8;
	localparam int AMC_EXT_CONV_LSB = 4;
	localparam int AMC_SHUNT_CONV_LSB = 0;

	// channel groups, also the sequencer order
	localparam logic [1:0] AMC_GRP_SHUNT = 2'h0;
	localparam logic [1:0] AMC_GRP_EXT = 2'h1;
	localparam logic [1:0] AMC_GRP_TEMP = 2'h2;
	localparam logic [1:0] AMC_GRP_NONE = 2'h3;

	// interrupt status bits
	localparam int AMC_IRQ_SHUNT_ALARM = 0;
	localparam int AMC_IRQ_EXT_ALARM = 1;
	localparam int AMC_IRQ_TEMP_ALARM = 2;
	localparam int AMC_IRQ_PASS_DONE = 3;

	// clock rate and conversion times in microseconds
	localparam int AMC_CLK_MHZ = 250;
	localparam int AMC_CONV_US_0 = 52;
	localparam int AMC_CONV_US_1 = 86;
	localparam int AMC_CONV_US_2 = 152;
	localparam int AMC_CONV_US_3 = 282;
	localparam int AMC_CONV_US_4 = 542;
	localparam int AMC_CONV_US_5 = 1054;
	localparam int AMC_CONV_US_6 = 2076;
	localparam int AMC_CONV_US_7 = 4122;
	localparam int AMC_TIMER_W = 24;

	typedef enum logic [1:0] {
		AMC_SEQ_IDLE = 2'b00,
		AMC_SEQ_CONVERT = 2'b01
	} amc_seq_state_t;

	// conversion time of one unaveraged measurement
	function automatic int amc_conv_us(input logic [2:0] code);
		case (code)
			3'h0: amc_conv_us = AMC_CONV_US_0;
			3'h1: amc_conv_us = AMC_CONV_US_1;
			3'h2: amc_conv_us = AMC_CONV_US_2;
			3'h3: amc_conv_us = AMC_CONV_US_3;
			3'h4: amc_conv_us = AMC_CONV_US_4;
			3'h5: amc_conv_us = AMC_CONV_US_5;
			3'h6: amc_conv_us = AMC_CONV_US_6;
			default: amc_conv_us = AMC_CONV_US_7;
		endcase
	endfunction

	// consecutive out-of-range results needed for an alarm
	function automatic logic [8:0] amc_filter_count(input logic [2:0] code);
		case (code)
			3'h0: amc_filter_count = 9'h001;
			3'h1: amc_filter_count = 9'h004;
			3'h2: amc_filter_count = 9'h008;
			3'h3: amc_filter_count = 9'h010;
			3'h4: amc_filter_count = 9'h020;
			3'h5: amc_filter_count = 9'h040;
			3'h6: amc_filter_count = 9'h080;
			default: amc_filter_count = 9'h100;
		endcase
	endfunction

endpackage

// file: core/amc_alarm_filter.sv
`timescale 1ns/1ps
`default_nettype none
module amc_alarm_filter
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [2:0] code,
	input wire logic sample,
	input wire logic out_of_range,
	output logic alarm
);
	import amc_pkg::*;

	logic [8:0] run;
	logic [8:0] thr;
	logic [8:0] next_run;

	// saturate the run at the threshold so it never wraps
	always_comb
	begin
		thr = amc_filter_count(code);
		next_run = (run < thr) ? run + 9'h001 : run;
	end

	// run length and alarm update once per finished conversion
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run <= 9'h000;
			alarm <= 1'b0;
		end
		else if (sample)
		begin
			if (out_of_range)
			begin
				run <= next_run;
				alarm <= (next_run >= thr);
			end
			else
			begin
				run <= 9'h000;
				alarm <= 1'b0;
			end
		end
	end

	property p_rise_at_count;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(alarm) |-> (run == thr) || (run > thr);
	endproperty
	a_rise_at_count: assert property (p_rise_at_count)
		else $error("alarm rose before the run reached the filter count");

	property p_in_range_clears;
		@(posedge core_clk) disable iff (!rst_n)
		sample && !out_of_range |=> run == 9'h000 && !alarm;
	endproperty
	a_in_range_clears: assert property (p_in_range_clears)
		else $error("in-range result did not clear the run");

endmodule
`default_nettype wire

// file: core/amc_top.sv
// How it works
// - external-input alarm filter at bits 14-12, reset 3, needs 1..256 bad results
// - shunt alarm filter at bits 10-8, reset 3, same count table
// - temperature alarm filter at bits 6-4, reset 3, same count table
// - code 000 alarms on one bad result; others need an unbroken run
// - conversion mode bit 2 resets to 1, so conversions run continuously
// - mode 0 converts the listed groups once, then idles for a trigger
// - mode 1 restarts at the first listed group after each pass
// - shunt range bit 1 resets 0: 0 is 163.84mV, 1 is 40.96mV
// - temperature conversion time at timing bits 10-8, reset 5
// - external-input conversion time at timing bits 6-4, reset 5
// - shunt conversion time at timing bits 2-0, reset 5
// - codes map to 52..4122 us per measurement; reset code is 1054 us
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module amc_top
#(
	parameter int CYCLES_PER_US = amc_pkg::AMC_CLK_MHZ
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rd_data,
	input wire logic [2:0] seq_group_enable,
	input wire logic conv_trigger,
	input wire logic [2:0] result_out_of_range,
	output logic conv_busy,
	output logic [1:0] conv_group,
	output logic conv_strobe,
	output logic shunt_range,
	output logic [2:0] alarm,
	output logic irq
);
	import amc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta;
	logic rst_n;

	// two-stage release so the deassertion edge is clean
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [15:0] gen_cfg;
	logic [15:0] conv_timing;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;
	amc_seq_state_t state;
	logic [AMC_TIMER_W-1:0] timer;
	logic [AMC_TIMER_W-1:0] cur_cycles;
	logic [AMC_TIMER_W-1:0] conv_age;
	logic [1:0] grp;
	logic [2:0] filter_alarm;
	logic [2:0] alarm_q;
	logic conv_done;
	logic pass_done;
	logic start_pass;
	logic load;
	logic [1:0] first_grp;
	logic [1:0] after_grp;
	logic [1:0] load_grp;
	logic auto_mode;

	function automatic logic [1:0] next_enabled(input logic [1:0] from, input logic [2:0] en);
		logic [1:0] pick;
		pick = AMC_GRP_NONE;
		for (int i = 2; i >= 0; i--)
		begin
			if (en[i] && (i > int'(from) || from == AMC_GRP_NONE))
				pick = 2'(i);
		end
		return pick;
	endfunction

	function automatic logic [AMC_TIMER_W-1:0] group_cycles(input logic [1:0] g,
		input logic [15:0] t);
		logic [2:0] code;
		code = t[AMC_SHUNT_CONV_LSB +: 3];
		if (g == AMC_GRP_EXT)
			code = t[AMC_EXT_CONV_LSB +: 3];
		else if (g == AMC_GRP_TEMP)
			code = t[AMC_TEMP_CONV_LSB +: 3];
		return AMC_TIMER_W'(amc_conv_us(code) * CYCLES_PER_US);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register port

	// configuration writes keep only defined bits
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gen_cfg <= AMC_GEN_CFG_RST;
			conv_timing <= AMC_CONV_TIMING_RST;
			irq_mask <= AMC_IRQ_MASK_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == AMC_ADDR_GEN_CFG)
				gen_cfg <= reg_wr_data & AMC_GEN_CFG_WMASK;
			if (reg_addr == AMC_ADDR_CONV_TIMING)
				conv_timing <= reg_wr_data & AMC_CONV_TIMING_WMASK;
			if (reg_addr == AMC_ADDR_IRQ_MASK)
				irq_mask <= reg_wr_data[3:0];
		end
	end

	// read data only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rd_data <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				AMC_ADDR_GEN_CFG: reg_rd_data <= gen_cfg;
				AMC_ADDR_CONV_TIMING: reg_rd_data <= conv_timing;
				AMC_ADDR_IRQ_STATUS: reg_rd_data <= {12'h000, irq_status};
				AMC_ADDR_IRQ_MASK: reg_rd_data <= {12'h000, irq_mask};
				default: reg_rd_data <= 16'h0000;
			endcase
		end
		else
			reg_rd_data <= 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb
	begin
		auto_mode = gen_cfg[AMC_MODE_BIT];
		first_grp = next_enabled(AMC_GRP_NONE, seq_group_enable);
		after_grp = next_enabled(grp, seq_group_enable);
		conv_done = (state == AMC_SEQ_CONVERT) && (timer == AMC_TIMER_W'(1));
		pass_done = conv_done && (after_grp == AMC_GRP_NONE);
		// auto mode restarts by itself; direct mode waits for a trigger
		start_pass = (first_grp != AMC_GRP_NONE) && (auto_mode || conv_trigger);
		load = ((state == AMC_SEQ_IDLE) && start_pass) ||
			(conv_done && (!pass_done || start_pass && auto_mode));
		load_grp = (conv_done && !pass_done) ? after_grp : first_grp;
	end

	// mode is sampled at the end of a pass, so a change mid-pass finishes it
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= AMC_SEQ_IDLE;
			grp <= AMC_GRP_SHUNT;
			timer <= '0;
			cur_cycles <= '0;
		end
		else if (load)
		begin
			state <= AMC_SEQ_CONVERT;
			grp <= load_grp;
			timer <= group_cycles(load_grp, conv_timing);
			cur_cycles <= group_cycles(load_grp, conv_timing);
		end
		else
		begin
			case (state)
				AMC_SEQ_IDLE: state <= AMC_SEQ_IDLE;
				AMC_SEQ_CONVERT:
				begin
					if (conv_done)
						state <= AMC_SEQ_IDLE;
					timer <= timer - AMC_TIMER_W'(1);
				end
				default: state <= AMC_SEQ_IDLE;
			endcase
		end
	end

	// sequencer status pins
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			conv_busy <= 1'b0;
			conv_group <= AMC_GRP_SHUNT;
			conv_strobe <= 1'b0;
			shunt_range <= 1'b0;
		end
		else
		begin
			conv_busy <= load || (state == AMC_SEQ_CONVERT && !conv_done);
			conv_group <= load ? load_grp : grp;
			conv_strobe <= conv_done;
			shunt_range <= gen_cfg[AMC_SHUNT_RANGE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alarm filters, one per group

	for (genvar g = 0; g < 3; g++)
	begin : g_filter
		localparam int LSB = (g == 0) ? AMC_SHUNT_FILTER_LSB :
			(g == 1) ? AMC_EXT_FILTER_LSB : AMC_TEMP_FILTER_LSB;
		amc_alarm_filter u_filter
		(
			.core_clk(core_clk),
			.rst_n(rst_n),
			.code(gen_cfg[LSB +: 3]),
			.sample(conv_done && grp == 2'(g)),
			.out_of_range(result_out_of_range[g]),
			.alarm(filter_alarm[g])
		);
	end

	assign alarm = filter_alarm;

	////////////////////////////////////////////////////////////////////////
	// interrupts

	// set beats a same-cycle write-one clear, so no event is lost
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_status <= AMC_IRQ_STATUS_RST;
			alarm_q <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			alarm_q <= filter_alarm;
			irq_status <= (irq_status &
				~((reg_wr && reg_addr == AMC_ADDR_IRQ_STATUS) ? reg_wr_data[3:0] : 4'h0)) |
				{pass_done, filter_alarm & ~alarm_q};
			irq <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	// age of the running conversion, read only by the checks
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			conv_age <= '0;
		else if (load)
			conv_age <= '0;
		else
			conv_age <= conv_age + AMC_TIMER_W'(1);
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_reset_values;
		$rose(rst_n) |-> gen_cfg == 16'h3334 && conv_timing == 16'h0555 && !shunt_range;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("configuration reset values wrong");

	property p_reserved_zero;
		reg_rd && reg_addr == AMC_ADDR_GEN_CFG |=> (reg_rd_data & 16'h8889) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved configuration bit read nonzero");

	property p_timing_reserved;
		reg_rd && reg_addr == AMC_ADDR_CONV_TIMING |=> reg_rd_data[15:11] == 5'h00 &&
			!reg_rd_data[7] && !reg_rd_data[3];
	endproperty
	a_timing_reserved: assert property (p_timing_reserved)
		else $error("reserved timing bit read nonzero");

	property p_direct_idles;
		pass_done && !auto_mode ##1 !conv_trigger [*2] |-> !conv_busy;
	endproperty
	a_direct_idles: assert property (p_direct_idles)
		else $error("direct mode did not go idle after one pass");

	property p_auto_repeats;
		pass_done && auto_mode && first_grp != AMC_GRP_NONE |=>
			state == AMC_SEQ_CONVERT && grp == $past(first_grp);
	endproperty
	a_auto_repeats: assert property (p_auto_repeats)
		else $error("auto mode did not restart at the first group");

	property p_conv_length;
		conv_done |-> conv_age == cur_cycles - AMC_TIMER_W'(1);
	endproperty
	a_conv_length: assert property (p_conv_length)
		else $error("conversion length differs from selected time");

	property p_range_follows;
		reg_wr && reg_addr == AMC_ADDR_GEN_CFG |-> ##2 shunt_range == $past(reg_wr_data[1], 2);
	endproperty
	a_range_follows: assert property (p_range_follows)
		else $error("shunt range pin does not follow its bit");

	property p_single_alarm;
		conv_done && grp == AMC_GRP_EXT && gen_cfg[14:12] == 3'h0 && result_out_of_range[1]
			|=> alarm[1];
	endproperty
	a_single_alarm: assert property (p_single_alarm)
		else $error("code zero did not alarm on one bad result");

	property p_clear_on_range;
		conv_done && grp == AMC_GRP_TEMP && !result_out_of_range[2] |=> !alarm[2];
	endproperty
	a_clear_on_range: assert property (p_clear_on_range)
		else $error("in-range temperature result kept the alarm");

	c_auto_pass: cover property (pass_done && auto_mode ##1 conv_busy);
	c_direct_pass: cover property (conv_trigger && !auto_mode ##[1:1000] pass_done);
	c_ext_alarm: cover property ($rose(alarm[1]));
	c_irq: cover property ($rose(irq));

endmodule
`default_nettype wire

// file: verif/adc_monitor_alarm_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_monitor_alarm_config_bench;
	import amc_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wr_data = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rd_data;
	logic [2:0] seq_group_enable = 3'h0;
	logic conv_trigger = 1'b0;
	logic [2:0] result_out_of_range = 3'h0;
	logic conv_busy;
	logic [1:0] conv_group;
	logic conv_strobe;
	logic shunt_range;
	logic [2:0] alarm;
	logic irq;
	int n_errors = 0;
	int compares = 0;
	int k;
	typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} amc_row_t;
	// register rows: address, write data, expected read back
	// the mask goes back to zero so the irq test starts from a masked state
	amc_row_t rows [7] = '{'{8'h40, 16'hFFFF, 16'h7776}, '{8'h41, 16'hFFFF, 16'h0777},
		'{8'h61, 16'hFFFF, 16'h000F}, '{8'h7F, 16'hFFFF, 16'h0000},
		'{8'h41, 16'h0000, 16'h0000}, '{8'h40, 16'h0000, 16'h0000},
		'{8'h61, 16'h0000, 16'h0000}};
	// pass rows: out-of-range pattern in the top bits, expected alarms below
	logic [5:0] passes [9] = '{6'h3E, 6'h3E, 6'h3E, 6'h3F, 6'h00, 6'h08, 6'h08, 6'h08, 6'h09};
	// auto-mode period per shunt conversion-time code, one cycle per microsecond
	logic [15:0] codes [3] = '{16'h0000, 16'h0001, 16'h0005};
	int periods [3] = '{52, 86, 1054};

	always #2 core_clk = ~core_clk;

	amc_top #(.CYCLES_PER_US(1)) dut_u
	(
		.core_clk(core_clk),
		.arst_n(arst_n),
		.reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rd_data(reg_rd_data),
		.seq_group_enable(seq_group_enable),
		.conv_trigger(conv_trigger),
		.result_out_of_range(result_out_of_range),
		.conv_busy(conv_busy),
		.conv_group(conv_group),
		.conv_strobe(conv_strobe),
		.shunt_range(shunt_range),
		.alarm(alarm),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
		begin
			$display("bench passed");
		end
		else
		begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	// sample one step after the edge so that edge's updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input string m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rd_data, e, m);
	endtask

	// bounded waits; running out ends the run as a mismatch
	task automatic wait_busy(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && conv_busy !== v; i++)
			cyc(1);
		if (conv_busy !== v)
		begin
			chk(16'h0001, 16'h0000, "busy wait timed out");
			summarize();
		end
	endtask

	task automatic wait_strobe(input int lim, output int n);
		n = 0;
		do
		begin
			cyc(1);
			n++;
		end
		while (conv_strobe !== 1'b1 && n < lim);
		if (conv_strobe !== 1'b1)
		begin
			chk(16'h0001, 16'h0000, "strobe wait timed out");
			summarize();
		end
	endtask

	// one direct-mode pass started by a trigger pulse
	// group times follow timing codes 0, 1 and 2, so a swapped field shows up
	task automatic run_pass(input logic [2:0] oor);
		@(posedge core_clk);
		result_out_of_range <= oor;
		conv_trigger <= 1'b1;
		@(posedge core_clk);
		conv_trigger <= 1'b0;
		#1;
		wait_busy(1'b1, 4);
		chk({14'h0000, conv_group}, {14'h0000, AMC_GRP_SHUNT}, "first group");
		cyc(AMC_CONV_US_0);
		chk({14'h0000, conv_group}, {14'h0000, AMC_GRP_EXT}, "shunt time");
		cyc(AMC_CONV_US_1);
		chk({14'h0000, conv_group}, {14'h0000, AMC_GRP_TEMP}, "ext time");
		cyc(AMC_CONV_US_2 - 1);
		chk({15'h0000, conv_busy}, 16'h0001, "temp still busy");
		wait_busy(1'b0, 2);
		cyc(2);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		cyc(4);
		// ordinary register rows, reserved bits and an unmapped address among them
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e, "register row");
		end
		wr(AMC_ADDR_GEN_CFG, 16'h0002);
		cyc(2);
		chk({15'h0000, shunt_range}, 16'h0001, "shunt range set");
		$display("register test done");

		// direct mode, shunt needs a run of four, ext and temp need one
		wr(AMC_ADDR_CONV_TIMING, 16'h0210);
		wr(AMC_ADDR_GEN_CFG, 16'h0100);
		@(posedge core_clk);
		seq_group_enable <= 3'h7;
		foreach (passes[i])
		begin
			run_pass(passes[i][5:3]);
			chk({13'h0000, alarm}, {13'h0000, passes[i][2:0]}, "alarm");
		end
		cyc(100);
		chk({15'h0000, conv_busy}, 16'h0000, "direct mode restarted");
		$display("alarm test done");

		// status is sticky, masked until the mask bit is set, cleared by writing one
		rd(AMC_ADDR_IRQ_STATUS, 16'h000F, "status");
		chk({15'h0000, irq}, 16'h0000, "masked irq");
		wr(AMC_ADDR_IRQ_MASK, 16'h0001);
		cyc(2);
		chk({15'h0000, irq}, 16'h0001, "irq raised");
		wr(AMC_ADDR_IRQ_STATUS, 16'h000F);
		cyc(2);
		chk({15'h0000, irq}, 16'h0000, "irq cleared");
		rd(AMC_ADDR_IRQ_STATUS, 16'h0000, "status cleared");
		$display("irq test done");

		// auto mode repeats; the third strobe is surely on the new time code
		@(posedge core_clk);
		seq_group_enable <= 3'h1;
		wr(AMC_ADDR_GEN_CFG, 16'h0104);
		foreach (codes[i])
		begin
			wr(AMC_ADDR_CONV_TIMING, codes[i]);
			wait_strobe(5000, k);
			wait_strobe(5000, k);
			wait_strobe(5000, k);
			chk(k[15:0], periods[i][15:0], "auto period");
		end
		$display("period test done");

		// second reset in mid-run; auto mode starts again by itself
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		cyc(4);
		rd(AMC_ADDR_GEN_CFG, 16'h3334, "general reset");
		rd(AMC_ADDR_CONV_TIMING, 16'h0555, "timing reset");
		rd(AMC_ADDR_IRQ_STATUS, 16'h0000, "status reset");
		rd(AMC_ADDR_IRQ_MASK, 16'h0000, "mask reset");
		chk({15'h0000, shunt_range}, 16'h0000, "range reset");
		chk({15'h0000, conv_busy}, 16'h0001, "auto start");
		$display("reset test done");
		summarize();
	end
endmodule
`default_nettype wire
